//--- design/dspao_adder_out.sv
// adder/output stage of the hard multiply block
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
module dspao_adder_out
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [35:0] prod0_i,
  input wire logic [35:0] prod1_i,
  input wire logic [35:0] prod2_i,
  input wire logic [35:0] prod3_i,
  input wire logic sign_a_i,
  input wire logic sign_b_i,
  input wire logic [1:0] add_sub_i,
  input wire logic [1:0] acc_load_i,
  input wire logic [3:0] aclr_i,
  input wire logic [3:0] ena_i,
  output logic [143:0] result_o,
  output logic [1:0] overflow_o
);
  typedef struct packed
  {
    logic [3:0][35:0] pp;
    logic [1:0][51:0] acc;
    logic [1:0] ovf;
    logic [143:0] ob;
    logic [143:0] res;
  } dspao_st_t;

  dspao_st_t s_q;
  dspao_st_t s_d;
  logic [31:0] ctrl;
  logic [31:0] stat;
  dspao_pkg::dspao_mode_t mode;
  logic [1:0] size;
  logic is_mac;
  logic nine;
  logic pipe_en;
  logic use_ob;
  logic pclr;
  logic pen;
  logic oclr;
  logic oen;
  logic [1:0] asub;
  logic [1:0] sg;
  logic [1:0] ld;
  logic sgn;
  logic [3:0][35:0] pv;
  logic [1:0][71:0] fl18;
  logic [3:0][35:0] fl9;
  logic [1:0][71:0] s9;
  logic [71:0] s18;
  logic [71:0] full;
  logic [1:0][51:0] bx;
  logic [1:0][52:0] sum;
  logic [1:0] ovf;
  logic [143:0] mx;

  function automatic logic [71:0] x72(input logic [35:0] v, input logic s);
    x72 = {{dspao_pkg::PW{s & v[35]}}, v};
  endfunction

  function automatic logic [35:0] x36(input logic [17:0] v, input logic s);
    x36 = {{dspao_pkg::HW{s & v[17]}}, v};
  endfunction

  dspao_apb_regs u_regs
  (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .stat_i(stat),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .ctrl_o(ctrl)
  );

  // configuration fields
  assign mode = dspao_pkg::dspao_mode_t'(ctrl[dspao_pkg::F_MODE +: 2]);
  assign size = ctrl[dspao_pkg::F_SIZE +: 2];
  assign pipe_en = ctrl[dspao_pkg::F_PIPE];
  assign is_mac = mode == dspao_pkg::DSPAO_MAC;
  assign nine = size == dspao_pkg::SZ_9;
  assign use_ob = ctrl[dspao_pkg::F_OUT] && !is_mac;
  assign stat = {28'h0, mode, s_q.ovf};

  // control set per register group
  assign pclr = aclr_i[ctrl[dspao_pkg::F_PSET +: 2]];
  assign pen = ena_i[ctrl[dspao_pkg::F_PSET +: 2]];
  assign oclr = aclr_i[ctrl[dspao_pkg::F_OSET +: 2]];
  assign oen = ena_i[ctrl[dspao_pkg::F_OSET +: 2]];

  dspao_lat_line #(.W(2)) u_as_lat
  (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .lat_i(ctrl[dspao_pkg::F_ASL +: 2]),
    .d_i(add_sub_i),
    .q_o(asub)
  );

  dspao_lat_line #(.W(2)) u_sg_lat
  (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .lat_i(ctrl[dspao_pkg::F_SGL +: 2]),
    .d_i({sign_b_i, sign_a_i}),
    .q_o(sg)
  );

  dspao_lat_line #(.W(2)) u_ld_lat
  (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .lat_i(ctrl[dspao_pkg::F_LDL +: 2]),
    .d_i(acc_load_i),
    .q_o(ld)
  );

  // either operand signed makes the product signed
  assign sgn = sg[0] | sg[1];

  // products, optionally through the pipeline register
  assign pv = pipe_en ? s_q.pp : {prod3_i, prod2_i, prod1_i, prod0_i};

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_pair
      // 18x18 first level: one control per adder
      assign fl18[g] = asub[g] ? x72(pv[2*g], sgn) + x72(pv[2*g+1], sgn)
                               : x72(pv[2*g], sgn) - x72(pv[2*g+1], sgn);
      // accumulator fed by second or fourth product only
      assign bx[g] = {{dspao_pkg::GW{sgn & pv[2*g+1][35]}}, pv[2*g+1]};
      assign sum[g] = asub[g] ? {1'b0, s_q.acc[g]} + {1'b0, bx[g]}
                              : {1'b0, s_q.acc[g]} - {1'b0, bx[g]};
      // signed overflow or unsigned carry/borrow
      assign ovf[g] = sgn ? ((asub[g] ? (s_q.acc[g][51] == bx[g][51]) : (s_q.acc[g][51] != bx[g][51]))
                             && (sum[g][51] != s_q.acc[g][51]))
                          : sum[g][52];
      // 9x9 second level: four products per sum
      assign s9[g] = x72(fl9[2*g+1], 1'b1) + x72(fl9[2*g], 1'b1);
    end
    for (g = 0; g < 4; g++)
    begin : g_nine
      // top two adders share one control, bottom two the other
      assign fl9[g] = asub[g/2] ? x36(pv[2*(g/2)][dspao_pkg::HW*(g%2) +: 18], sgn)
                                  + x36(pv[2*(g/2)+1][dspao_pkg::HW*(g%2) +: 18], sgn)
                                : x36(pv[2*(g/2)][dspao_pkg::HW*(g%2) +: 18], sgn)
                                  - x36(pv[2*(g/2)+1][dspao_pkg::HW*(g%2) +: 18], sgn);
    end
  endgenerate

  assign s18 = fl18[0] + fl18[1];

  // 36x36 from four partials: lo*lo, hi*lo, lo*hi, hi*hi
  assign full = x72(pv[0], 1'b0)
                + (x72(pv[1], sg[0]) << dspao_pkg::HW)
                + (x72(pv[2], sg[1]) << dspao_pkg::HW)
                + (x72(pv[3], sgn) << dspao_pkg::PW);

  // output selection
  always_comb
  begin
    unique case (mode)
      dspao_pkg::DSPAO_SIMPLE:
      begin
        if (size == dspao_pkg::SZ_36)
          mx = {72'h0, full};
        else
          mx = pv;
      end
      dspao_pkg::DSPAO_MAC:
      begin
        mx = {{dspao_pkg::XW{sgn & s_q.acc[1][51]}}, s_q.acc[1],
              {dspao_pkg::XW{sgn & s_q.acc[0][51]}}, s_q.acc[0]};
      end
      dspao_pkg::DSPAO_ADD2:
      begin
        mx = nine ? fl9 : fl18;
      end
      dspao_pkg::DSPAO_ADD4:
      begin
        mx = nine ? s9 : {{72{s18[71]}}, s18};
      end
    endcase
  end

  // next state
  always_comb
  begin
    s_d = s_q;
    s_d.res = use_ob ? s_q.ob : mx;
    if (pclr)
      s_d.pp = 144'h0;
    else if (pen)
      s_d.pp = {prod3_i, prod2_i, prod1_i, prod0_i};
    if (oclr)
    begin
      s_d.ob = 144'h0;
      s_d.acc = 104'h0;
      s_d.ovf = 2'h0;
    end
    else if (oen)
    begin
      s_d.ob = mx;
      if (is_mac)
      begin
        for (int k = 0; k < 2; k++)
        begin
          s_d.acc[k] = ld[k] ? bx[k] : sum[k][51:0];
          s_d.ovf[k] = !ld[k] && ovf[k];
        end
      end
    end
    if (!is_mac)
      s_d.ovf = 2'h0;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      s_q <= {$bits(dspao_st_t){1'b0}};
    else
      s_q <= s_d;
  end

  assign result_o = s_q.res;
  assign overflow_o = s_q.ovf;

  default clocking dspao_cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_acc_go;
    is_mac && oen && !oclr;
  endsequence

  sequence s_ob_load;
    use_ob && oen && !oclr ##1 use_ob;
  endsequence

  sequence s_direct;
    !use_ob && !pipe_en;
  endsequence

  a_acc_load: assert property (s_acc_go ##0 ld[0] |=> s_q.acc[0] == $past(bx[0]))
    else $error("accumulator load did not take the product");

  a_acc_step: assert property (s_acc_go ##0 !ld[0] |=>
    s_q.acc[0] == ($past(asub[0]) ? $past(s_q.acc[0]) + $past(bx[0]) : $past(s_q.acc[0]) - $past(bx[0])))
    else $error("accumulator step wrong");

  a_clear_zero: assert property (oclr |=> s_q.ob == 144'h0 && s_q.acc == 104'h0 && overflow_o == 2'h0)
    else $error("clear did not zero registers");

  a_ovf_mode: assert property (!is_mac |=> overflow_o == 2'h0)
    else $error("overflow outside accumulate mode");

  a_ovf_clear: assert property (s_acc_go ##0 ld[0] |=> !overflow_o[0])
    else $error("overflow held across load");

  a_ovf_flag: assert property (s_acc_go ##0 (!ld[0] && ovf[0]) |=> overflow_o[0])
    else $error("overflow not reported");

  a_out_direct: assert property (!use_ob |=> result_o == $past(mx))
    else $error("bypassed output wrong");

  a_out_reg: assert property (s_ob_load |=> result_o == $past(mx, 2))
    else $error("registered output wrong");

  a_pipe_hold: assert property (!pen && !pclr |=> s_q.pp == $past(s_q.pp))
    else $error("pipeline moved without enable");

  a_first_add: assert property (!nine && mode == dspao_pkg::DSPAO_ADD2 && !use_ob ##0 asub[0]
    |=> result_o[71:0] == $past(x72(pv[0], sgn) + x72(pv[1], sgn)))
    else $error("first level add wrong");

  a_first_sub: assert property (s_direct ##0 (!nine && mode == dspao_pkg::DSPAO_ADD2 && !asub[0])
    |=> result_o[71:0] == $past(x72(prod0_i, sgn) - x72(prod1_i, sgn)))
    else $error("first level subtract wrong");

  a_simple_out: assert property (s_direct ##0 (mode == dspao_pkg::DSPAO_SIMPLE && size != dspao_pkg::SZ_36)
    |=> result_o == $past({prod3_i, prod2_i, prod1_i, prod0_i}))
    else $error("simple mode output wrong");

  a_wide_prod: assert property (s_direct ##0 (mode == dspao_pkg::DSPAO_SIMPLE && size == dspao_pkg::SZ_36 && sg == 2'h0)
    |=> result_o[71:0] == $past(72'(prod0_i) + (72'(prod1_i) << dspao_pkg::HW) + (72'(prod2_i) << dspao_pkg::HW)
    + (72'(prod3_i) << dspao_pkg::PW)))
    else $error("wide unsigned product wrong");

  a_wide_upper: assert property (mode == dspao_pkg::DSPAO_SIMPLE && size == dspao_pkg::SZ_36 && !use_ob
    |=> result_o[143:72] == 72'h0)
    else $error("wide product upper half not zero");

  a_four_sum: assert property (s_direct ##0 (!nine && mode == dspao_pkg::DSPAO_ADD4 && asub == 2'h3)
    |=> result_o[71:0] == $past(x72(prod0_i, sgn) + x72(prod1_i, sgn) + x72(prod2_i, sgn) + x72(prod3_i, sgn)))
    else $error("four product sum wrong");

  a_nine_add: assert property (s_direct ##0 (nine && mode == dspao_pkg::DSPAO_ADD2 && asub[0])
    |=> result_o[35:0] == $past(x36(prod0_i[17:0], sgn) + x36(prod1_i[17:0], sgn)))
    else $error("small product pair sum wrong");

  a_pipe_load: assert property (pen && !pclr |=> s_q.pp == $past({prod3_i, prod2_i, prod1_i, prod0_i}))
    else $error("pipeline did not take products");

  a_pipe_clear: assert property (pclr |=> s_q.pp == 144'h0)
    else $error("pipeline not cleared");

  a_acc1_load: assert property (s_acc_go ##0 ld[1] |=> s_q.acc[1] == $past(bx[1]))
    else $error("second accumulator load wrong");

  a_ovf_under: assert property (s_acc_go ##0 (!ld[0] && !sgn && !asub[0] && s_q.acc[0] < bx[0])
    |=> overflow_o[0])
    else $error("underflow not reported");

  a_acc_hold: assert property (!oen && !oclr |=> s_q.acc == $past(s_q.acc))
    else $error("accumulator moved without enable");

  a_ovf_hold: assert property (is_mac && !oen && !oclr |=> overflow_o == $past(overflow_o))
    else $error("overflow moved without enable");

  a_mac_out: assert property (is_mac |=> result_o[51:0] == $past(s_q.acc[0]))
    else $error("accumulator not on output");
endmodule

//--- design/dspao_apb_regs.sv
// apb register slave for the adder/output stage
`timescale 1ns/1ps
module dspao_apb_regs
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] stat_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic [31:0] ctrl_o
);
  typedef struct packed
  {
    logic [31:0] ctrl;
    logic [31:0] rdata;
    logic rdy;
    logic err;
  } dspao_apb_st_t;

  dspao_apb_st_t s_q;
  dspao_apb_st_t s_d;
  logic hit_c;
  logic hit_s;

  assign hit_c = paddr_i == dspao_pkg::CTRL_OFS;
  assign hit_s = paddr_i == dspao_pkg::STAT_OFS;

  // answer prepared in setup, shown through the access phase
  always_comb
  begin
    s_d = s_q;
    s_d.rdy = 1'b0;
    s_d.err = 1'b0;
    s_d.rdata = 32'h0;
    if (psel_i && !penable_i)
    begin
      s_d.rdy = 1'b1;
      s_d.err = !(hit_c || hit_s);
      if (!pwrite_i)
        s_d.rdata = hit_c ? s_q.ctrl : (hit_s ? stat_i : 32'h0);
    end
    if (psel_i && penable_i && s_q.rdy && pwrite_i && hit_c)
      s_d.ctrl = pwdata_i & dspao_pkg::CTRL_MASK;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      s_q <= '{ctrl: dspao_pkg::CTRL_RST, rdata: 32'h0, rdy: 1'b0, err: 1'b0};
    else
      s_q <= s_d;
  end

  assign prdata_o = s_q.rdata;
  assign pready_o = s_q.rdy;
  assign pslverr_o = s_q.err;
  assign ctrl_o = s_q.ctrl;
endmodule

//--- design/dspao_lat_line.sv
// selectable zero, one or two stage control delay
`timescale 1ns/1ps
module dspao_lat_line
#(
  parameter int W = 2
)
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [1:0] lat_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed
  {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dspao_lat_st_t;

  dspao_lat_st_t s_q;
  dspao_lat_st_t s_d;

  always_comb
  begin
    s_d.s1 = d_i;
    s_d.s2 = s_q.s1;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      s_q <= {$bits(dspao_lat_st_t){1'b0}};
    else
      s_q <= s_d;
  end

  assign q_o = (lat_i == dspao_pkg::LAT_0) ? d_i : ((lat_i == dspao_pkg::LAT_1) ? s_q.s1 : s_q.s2);

  a_two_stage: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (lat_i == dspao_pkg::LAT_2) [*3] |-> q_o == $past(d_i, 2))
    else $error("two stage delay mismatch");
endmodule

//--- include/dspao_pkg.sv
// constants and types for the dsp adder/output stage
// Functional notes
// - optional product pipeline; also pipelines 36-bit multiply
// - output registers optional; forced for accumulator
// - operands come only from multiplier products
// - add_sub high adds, low subtracts
// - two add_sub controls; 9x9 uses top/bottom pairs
// - add_sub delayed by zero, one or two stages
// - signs match multiplier, delayed up to two
// - load replaces accumulator with current product
// - registered, non-sticky overflow/underflow flag
// - summation: two 9x9 sums or one 18x18
// - mode picks product, adder or sum output
// - registers use one of four control sets
// - one mode per block, never mixed
// - simple mode routes products straight out, except 36-bit size which outputs the combined product
// - 36x36 built from four 18x18 partials
// - two accumulators fed by second, fourth products
// - accumulator 52 bits: 36 plus 16 guard
// - load and overflow only in accumulate mode
// - two-multiplier adder gives two or four sums
// - complex product: subtractor real, adder imaginary
// - four-multiplier adder sums two first-level results
// - sign 1 signed; either signed gives signed
package dspao_pkg;
  typedef enum logic [1:0]
  {
    DSPAO_SIMPLE = 2'h0,
    DSPAO_MAC = 2'h1,
    DSPAO_ADD2 = 2'h2,
    DSPAO_ADD4 = 2'h3
  } dspao_mode_t;
  localparam logic [1:0] SZ_9 = 2'h0;
  localparam logic [1:0] SZ_18 = 2'h1;
  localparam logic [1:0] SZ_36 = 2'h2;
  localparam logic [1:0] LAT_0 = 2'h0;
  localparam logic [1:0] LAT_1 = 2'h1;
  localparam logic [1:0] LAT_2 = 2'h2;
  localparam int HW = 18;
  localparam int PW = 36;
  localparam int GW = 16;
  localparam int XW = 20;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h0000_FFFF;
  localparam int F_MODE = 0;
  localparam int F_SIZE = 2;
  localparam int F_PIPE = 4;
  localparam int F_OUT = 5;
  localparam int F_ASL = 6;
  localparam int F_SGL = 8;
  localparam int F_LDL = 10;
  localparam int F_PSET = 12;
  localparam int F_OSET = 14;
endpackage

//--- verification/dspao_fabric_model.sv
// random operand and control source standing in for the fabric
`timescale 1ns/1ps
module dspao_fabric_model
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  output logic [35:0] prod0_o,
  output logic [35:0] prod1_o,
  output logic [35:0] prod2_o,
  output logic [35:0] prod3_o,
  output logic [1:0] add_sub_o,
  output logic [1:0] acc_load_o
);
  initial
  begin
    prod0_o = 36'h0;
    prod1_o = 36'h0;
    prod2_o = 36'h0;
    prod3_o = 36'h0;
    add_sub_o = 2'h3;
    acc_load_o = 2'h0;
    void'($urandom(32'h3280));
    forever
    begin
      @(posedge sys_clk_i);
      // all four products share one 36-bit width
      prod0_o <= 36'({$urandom, $urandom});
      prod1_o <= 36'({$urandom, $urandom});
      prod2_o <= 36'({$urandom, $urandom});
      prod3_o <= 36'({$urandom, $urandom});
      add_sub_o <= 2'($urandom);
      acc_load_o <= rst_i ? 2'h0 : {($urandom & 7) == 0, ($urandom & 7) == 0};
    end
  end
endmodule

//--- verification/tb_top.sv
// self-checking bench for the adder/output stage
`timescale 1ns/1ps
`define CHK(g, x) begin tests_run++; if ((g) !== (x)) begin bad_count++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, g, x); end end
module tb_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, r;
  logic pready, pslverr, e;
  logic sa = 1'b0;
  logic sb = 1'b0;
  logic [35:0] p0, p1, p2, p3;
  logic [1:0] add_sub, acc_load, ovf, a, b, ov;
  logic [17:0] u, v;
  logic [3:0][35:0] n9;
  logic [143:0] pk;
  logic [3:0] aclr = 4'h0;
  logic [3:0] ena = 4'hF;
  logic [143:0] result, f, hold;
  logic [71:0] x, y, z;
  logic [71:0] s[2];
  logic [51:0] acc[2];
  logic [52:0] t;
  logic [143:0] eq[$] = '{144'h0, 144'h0, 144'h0, 144'h0};
  logic [1:0] ash[$] = '{2'h0, 2'h0, 2'h0, 2'h0};
  logic [1:0] ldq[$] = '{2'h0, 2'h0, 2'h0, 2'h0};
  logic [1:0] ovq[$] = '{2'h0, 2'h0, 2'h0, 2'h0};
  int bad_count = 0;
  int tests_run = 0;
  int md = 0;
  int sz = 0;
  int lat = 1;
  int asl = 0;
  int os = 0;
  int warm = 8;
  bit chk = 0;

  dspao_adder_out dut (.sys_clk_i(sys_clk), .rst_i(rst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .prod0_i(p0), .prod1_i(p1), .prod2_i(p2), .prod3_i(p3), .sign_a_i(sa),
    .sign_b_i(sb), .add_sub_i(add_sub), .acc_load_i(acc_load), .aclr_i(aclr), .ena_i(ena),
    .result_o(result), .overflow_o(ovf));
  dspao_fabric_model fab (.sys_clk_i(sys_clk), .rst_i(rst), .prod0_o(p0), .prod1_o(p1),
    .prod2_o(p2), .prod3_o(p3), .add_sub_o(add_sub), .acc_load_o(acc_load));

  initial
  begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  function automatic logic [71:0] sx(input logic [35:0] v);
    return {{36{v[35]}}, v};
  endfunction

  task automatic summarize();
    $display("checks run %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic cfg(input int m, zs, pi, o, l, al, sg, o_s);
    chk = 0;
    apb(1'b1, 8'h00, 32'(m | zs << 2 | pi << 4 | o << 5 | al << 6 | sg << 8 | al << 10 | o_s << 14));
    md = m;
    sz = zs;
    lat = l;
    asl = al;
    os = o_s;
    warm = 6;
  endtask

  task automatic run(input int n);
    chk = 1;
    repeat (n) @(posedge sys_clk);
  endtask

  // reference model, one result per edge
  always @(posedge sys_clk)
  begin
    ash.push_back(add_sub);
    a = ash[$ - asl];
    ldq.push_back(acc_load);
    b = ldq[$ - asl];
    for (int k = 0; k < 2; k++)
    begin
      x = sx(k ? p2 : p0);
      y = sx(k ? p3 : p1);
      s[k] = a[k] ? x + y : x - y;
      if (aclr[os])
      begin
        acc[k] = 52'h0;
        ov[k] = 1'b0;
      end
      else if (ena[os] && md == 1)
      begin
        t = a[k] ? acc[k] + (k ? p3 : p1) : acc[k] - (k ? p3 : p1);
        acc[k] = b[k] ? 52'(k ? p3 : p1) : t[51:0];
        ov[k] = !b[k] && t[52];
      end
    end
    z = s[0] + s[1];
    pk = {p3, p2, p1, p0};
    for (int j = 0; j < 4; j++)
    begin
      u = pk[72 * (j / 2) + 18 * (j % 2) +: 18];
      v = pk[72 * (j / 2) + 36 + 18 * (j % 2) +: 18];
      n9[j] = a[j / 2] ? {{18{u[17]}}, u} + {{18{v[17]}}, v} : {{18{u[17]}}, u} - {{18{v[17]}}, v};
    end
    x = sx(n9[1]) + sx(n9[0]);
    y = sx(n9[3]) + sx(n9[2]);
    f = md == 1 ? {20'h0, acc[1], 20'h0, acc[0]} : md == 2 ? (sz == 0 ? n9 : {s[1], s[0]})
      : md == 3 ? (sz == 0 ? {y, x} : {{72{z[71]}}, z})
      : sz == 2 ? {72'h0, {36'h0, p0} + (({36'h0, p1} + {36'h0, p2}) << 18) + ({36'h0, p3} << 36)}
      : {p3, p2, p1, p0};
    eq.push_back(f);
    ovq.push_back(ov);
    if (chk && warm == 0)
    begin
      `CHK(result, eq[$ - lat])
      if (md == 1)
        `CHK(ovf, ovq[$ - 1])
    end
    if (warm > 0)
      warm--;
    if (eq.size() > 8)
    begin
      void'(eq.pop_front());
      void'(ash.pop_front());
      void'(ldq.pop_front());
      void'(ovq.pop_front());
    end
  end

  initial
  begin
    #20000;
    bad_count++;
    summarize();
  end

  initial
  begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    apb(1'b0, 8'h00, 32'h0);
    `CHK(r, 32'h0)
    apb(1'b1, 8'h00, 32'hFFFF_FFFF);
    apb(1'b0, 8'h00, 32'h0);
    `CHK(r, 32'h0000_FFFF)
    apb(1'b0, 8'h04, 32'h0);
    `CHK(r[3:2], 2'h3)
    apb(1'b1, 8'h08, 32'h1);
    `CHK({e, r}, {1'b1, 32'h0})
    sa <= 1'b1;
    cfg(0, 1, 0, 0, 1, 0, 0, 0);
    run(40);
    cfg(0, 1, 1, 1, 3, 0, 0, 0);
    run(40);
    sa <= 1'b0;
    cfg(0, 2, 0, 0, 1, 0, 0, 0);
    run(40);
    sa <= 1'b1;
    cfg(2, 1, 0, 0, 1, 0, 0, 0);
    run(40);
    cfg(2, 1, 0, 0, 1, 2, 2, 0);
    run(40);
    cfg(3, 1, 0, 0, 1, 0, 0, 0);
    run(40);
    cfg(2, 0, 0, 0, 1, 1, 0, 0);
    run(40);
    cfg(3, 0, 0, 0, 1, 0, 0, 0);
    run(40);
    sa <= 1'b0;
    cfg(1, 1, 0, 0, 2, 1, 0, 1);
    apb(1'b0, 8'h04, 32'h0);
    `CHK(r[3:2], 2'h1)
    aclr[1] <= 1'b1;
    repeat (3) @(posedge sys_clk);
    `CHK(result, 144'h0)
    aclr[1] <= 1'b0;
    warm = 4;
    run(60);
    chk = 0;
    ena[1] <= 1'b0;
    repeat (2) @(posedge sys_clk);
    hold = result;
    repeat (4) @(posedge sys_clk);
    `CHK(result, hold)
    ena[1] <= 1'b1;
    warm = 4;
    run(40);
    summarize();
  end
endmodule
